// *** rtl/alu_exec_defines.svh ***
`ifndef ALU_EXEC_DEFINES_SVH
`define ALU_EXEC_DEFINES_SVH

// data path widths
`define DATA_W 8
`define FILE_ADDR_W 7
`define BIT_SEL_W 3
`define BYTE_MSB 7
`define NIBBLE_MSB 3

// constant values
`define ZERO_BYTE 8'h00
`define ACC_RST 8'h00
`define DEST_ACC 1'b0
`define DEST_FILE 1'b1
`define FLAG_RST 1'b0

`endif

// *** rtl/alu_exec_pkg.sv ***
`default_nettype none
`include "alu_exec_defines.svh"

package alu_exec_pkg;

  // instruction selector on the command port
  typedef enum logic [3:0] {
    NO_OPERATION,
    ADD_LITERAL_TO_ACCUMULATOR,
    AND_FILE_WITH_ACCUMULATOR,
    ADD_ACCUMULATOR_AND_FILE,
    BIT_CLEAR_INSTR,
    BIT_SET_INSTR,
    AND_LITERAL_WITH_ACCUMULATOR,
    TEST_SKIP_IF_ONE,
    TEST_SKIP_IF_ZERO,
    ZERO_FILE_REGISTER
  } op_t;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } exec_state_t;

  typedef struct packed {
    exec_state_t state;
    logic [`DATA_W-1:0] acc;
    logic carry;
    logic nibble_overflow_bit;
    logic zero;
    logic skip_pending;
    op_t op;
    logic [`FILE_ADDR_W-1:0] addr;
    logic dest;
    logic [`BIT_SEL_W-1:0] bit_sel;
    logic [`DATA_W-1:0] literal;
    logic ready;
    logic done;
    logic skip;
    logic discarded;
    logic [`DATA_W-1:0] result;
  } core_state_t;

endpackage : alu_exec_pkg

`default_nettype wire

// *** rtl/alu_if.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "alu_exec_defines.svh"

interface alu_if;
  import alu_exec_pkg::*;
  op_t op;
  logic [`DATA_W-1:0] acc;
  logic [`DATA_W-1:0] operand;
  logic [`BIT_SEL_W-1:0] bit_sel;
  logic [`DATA_W-1:0] result;
  logic carry;
  logic nibble_carry;
  logic zero;
  logic bit_val;

  modport core (output op, output acc, output operand, output bit_sel,
                input result, input carry, input nibble_carry, input zero, input bit_val);
  modport unit (input op, input acc, input operand, input bit_sel,
                output result, output carry, output nibble_carry, output zero, output bit_val);
endinterface : alu_if

`default_nettype wire

// *** rtl/alu_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "alu_exec_defines.svh"

module alu_unit
  import alu_exec_pkg::*;
(
  alu_if.unit io
);

  logic [`DATA_W:0] sum;
  logic [`NIBBLE_MSB+1:0] nib_sum;
  logic [`DATA_W-1:0] bit_mask;

  always_comb begin
    sum = {1'b0, io.acc} + {1'b0, io.operand};
    nib_sum = {1'b0, io.acc[`NIBBLE_MSB:0]} + {1'b0, io.operand[`NIBBLE_MSB:0]};
    bit_mask = `DATA_W'(1) << io.bit_sel;
    io.carry = sum[`DATA_W]; // see RULE11
    io.nibble_carry = nib_sum[`NIBBLE_MSB+1]; // see RULE11
    io.bit_val = |(io.operand & bit_mask);
    unique case (io.op)
      ADD_LITERAL_TO_ACCUMULATOR, ADD_ACCUMULATOR_AND_FILE: io.result = sum[`DATA_W-1:0]; // see RULE1 see RULE4
      AND_LITERAL_WITH_ACCUMULATOR, AND_FILE_WITH_ACCUMULATOR: io.result = io.acc & io.operand; // see RULE2 see RULE7
      BIT_CLEAR_INSTR: io.result = io.operand & ~bit_mask; // see RULE5
      BIT_SET_INSTR: io.result = io.operand | bit_mask; // see RULE6
      ZERO_FILE_REGISTER: io.result = `ZERO_BYTE; // see RULE10
      default: io.result = io.operand;
    endcase
    io.zero = (io.result == `ZERO_BYTE); // see RULE11
  end

endmodule : alu_unit

`default_nettype wire

// *** rtl/file_ram.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "alu_exec_defines.svh"

module file_ram #(
  parameter int DATA_W = `DATA_W,
  parameter int ADDR_W = `FILE_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rd_en,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data
);

  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] rd_data_r;

  // storage has no reset, contents are unknown until written
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_r <= '0;
    end else if (i_rd_en) begin
      rd_data_r <= mem[i_rd_addr];
    end
  end

  assign o_rd_data = rd_data_r;

endmodule : file_ram

`default_nettype wire

// *** rtl/alu_bit_exec.sv ***
// Contract
// RULE1: add-literal adds the 8-bit literal to the accumulator, stores it there and updates carry, nibble carry, zero.
// RULE2: and-file ands the accumulator with file register 0..127 and updates only the zero flag.
// RULE3: destination select 0 sends an and-file or add-file result to the accumulator, 1 writes it back to the file register.
// RULE4: add-file adds accumulator and file register, routes by destination select, updates carry, nibble carry, zero.
// RULE5: bit-clear forces bit 0..7 of the file register low, keeps the other bits and touches no flag.
// RULE6: bit-set forces the selected bit of the file register high, keeps the other bits and touches no flag.
// RULE7: and-literal ands the accumulator with the literal, stores it there and updates only the zero flag.
// RULE8: test-skip-if-one runs the next instruction if the bit is 0, else discards it as a no-op cycle.
// RULE9: test-skip-if-zero runs the next instruction if the bit is 1, else discards it; no flag changes.
// RULE10: zero-file writes zero into the file register and always sets the zero flag.
// RULE11: zero flag means an all-zero result; carry is carry out of bit 7, nibble carry out of bit 3.
`timescale 1ns/1ns
`default_nettype none
`include "alu_exec_defines.svh"

module alu_bit_exec
  import alu_exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire op_t i_op,
  input wire logic [`FILE_ADDR_W-1:0] i_file_addr,
  input wire logic i_dest,
  input wire logic [`BIT_SEL_W-1:0] i_bit_sel,
  input wire logic [`DATA_W-1:0] i_literal,
  output logic o_ready,
  output logic o_done,
  output logic o_skip,
  output logic o_discarded,
  output logic [`DATA_W-1:0] o_result,
  output logic [`DATA_W-1:0] o_accum,
  output logic o_carry,
  output logic o_nibble_overflow_bit,
  output logic o_zero
);

  core_state_t s_r;
  core_state_t s_nxt;

  logic ram_rd_en;
  logic [`DATA_W-1:0] ram_rd_data;
  logic ram_wr_en;

  alu_if alu ();

  alu_unit u_alu (
    .io(alu.unit)
  );

  file_ram #(
    .DATA_W(`DATA_W),
    .ADDR_W(`FILE_ADDR_W)
  ) u_ram (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rd_en(ram_rd_en),
    .i_rd_addr(i_file_addr),
    .o_rd_data(ram_rd_data),
    .i_wr_en(ram_wr_en),
    .i_wr_addr(s_r.addr),
    .i_wr_data(alu.result)
  );

  // literal ops take the latched literal, all others the file register
  function automatic logic uses_literal(input op_t op);
    return (op == ADD_LITERAL_TO_ACCUMULATOR) || (op == AND_LITERAL_WITH_ACCUMULATOR);
  endfunction : uses_literal

  assign alu.op = s_r.op;
  assign alu.acc = s_r.acc;
  assign alu.bit_sel = s_r.bit_sel;
  assign alu.operand = uses_literal(s_r.op) ? s_r.literal : ram_rd_data;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.skip = 1'b0;
    s_nxt.discarded = 1'b0;
    ram_rd_en = 1'b0;
    ram_wr_en = 1'b0;
    unique case (s_r.state)
      ST_IDLE: begin
        if (i_valid && s_r.ready) begin
          s_nxt.op = i_op;
          s_nxt.addr = i_file_addr;
          s_nxt.dest = i_dest;
          s_nxt.bit_sel = i_bit_sel;
          s_nxt.literal = i_literal;
          s_nxt.ready = 1'b0;
          s_nxt.state = ST_EXEC;
          ram_rd_en = 1'b1;
        end
      end
      ST_EXEC: begin
        s_nxt.state = ST_IDLE;
        s_nxt.ready = 1'b1;
        s_nxt.done = 1'b1;
        if (s_r.skip_pending) begin
          // the instruction after a taken skip runs as a no-op cycle
          s_nxt.skip_pending = 1'b0; // see RULE8 see RULE9
          s_nxt.discarded = 1'b1;
        end else begin
          s_nxt.result = alu.result;
          unique case (s_r.op)
            ADD_LITERAL_TO_ACCUMULATOR: begin
              s_nxt.acc = alu.result; // see RULE1
              s_nxt.carry = alu.carry;
              s_nxt.nibble_overflow_bit = alu.nibble_carry;
              s_nxt.zero = alu.zero;
            end
            AND_LITERAL_WITH_ACCUMULATOR: begin
              s_nxt.acc = alu.result; // see RULE7
              s_nxt.zero = alu.zero;
            end
            AND_FILE_WITH_ACCUMULATOR: begin
              if (s_r.dest == `DEST_FILE) begin
                ram_wr_en = 1'b1; // see RULE3
              end else begin
                s_nxt.acc = alu.result; // see RULE3
              end
              s_nxt.zero = alu.zero; // see RULE2
            end
            ADD_ACCUMULATOR_AND_FILE: begin
              if (s_r.dest == `DEST_FILE) begin
                ram_wr_en = 1'b1; // see RULE3
              end else begin
                s_nxt.acc = alu.result; // see RULE3
              end
              s_nxt.carry = alu.carry; // see RULE4
              s_nxt.nibble_overflow_bit = alu.nibble_carry;
              s_nxt.zero = alu.zero;
            end
            BIT_CLEAR_INSTR: begin
              ram_wr_en = 1'b1; // see RULE5
            end
            BIT_SET_INSTR: begin
              ram_wr_en = 1'b1; // see RULE6
            end
            TEST_SKIP_IF_ONE: begin
              if (alu.bit_val) begin
                s_nxt.skip_pending = 1'b1; // see RULE8
                s_nxt.skip = 1'b1;
              end
            end
            TEST_SKIP_IF_ZERO: begin
              if (!alu.bit_val) begin
                s_nxt.skip_pending = 1'b1; // see RULE9
                s_nxt.skip = 1'b1;
              end
            end
            ZERO_FILE_REGISTER: begin
              ram_wr_en = 1'b1; // see RULE10
              s_nxt.zero = 1'b1; // see RULE10
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '{
        state: ST_IDLE,
        acc: `ACC_RST,
        carry: `FLAG_RST,
        nibble_overflow_bit: `FLAG_RST,
        zero: `FLAG_RST,
        skip_pending: 1'b0,
        op: NO_OPERATION,
        addr: '0,
        dest: `DEST_ACC,
        bit_sel: '0,
        literal: `ZERO_BYTE,
        ready: 1'b1,
        done: 1'b0,
        skip: 1'b0,
        discarded: 1'b0,
        result: `ZERO_BYTE
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_ready = s_r.ready;
  assign o_done = s_r.done;
  assign o_skip = s_r.skip;
  assign o_discarded = s_r.discarded;
  assign o_result = s_r.result;
  assign o_accum = s_r.acc;
  assign o_carry = s_r.carry;
  assign o_nibble_overflow_bit = s_r.nibble_overflow_bit;
  assign o_zero = s_r.zero;

endmodule : alu_bit_exec

`default_nettype wire

// *** tb/alu_bit_exec_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module alu_bit_exec_assertions
  import alu_exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire op_t i_op,
  input wire logic i_dest,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_literal,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_skip,
  input wire logic o_discarded,
  input wire logic [7:0] o_result,
  input wire logic [7:0] o_accum,
  input wire logic o_carry,
  input wire logic o_nibble_overflow_bit,
  input wire logic o_zero
);
  logic take;
  logic fin;
  assign take = o_ready && i_valid;
  assign fin = o_done && !o_discarded;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_take;
    take;
  endsequence
  sequence s_answer;
    !o_ready ##1 o_done;
  endsequence
  answer_timing_a: assert property (s_take |=> s_answer) else $error("late done");
  skip_with_done_a: assert property (o_skip |-> o_done && !o_discarded) else $error("lone skip");
  discard_holds_a: assert property (o_discarded |-> $stable(o_accum) && $stable(o_result) && $stable(o_zero)
    && $stable(o_carry) && $stable(o_nibble_overflow_bit)) else $error("discard changed state");
  add_literal_a: assert property (fin && $past(take && i_op == ADD_LITERAL_TO_ACCUMULATOR, 2)
    |-> {o_carry, o_accum} == {1'b0, $past(o_accum, 2)} + {1'b0, $past(i_literal, 2)}) else $error("bad sum");
  and_literal_a: assert property (fin && $past(take && i_op == AND_LITERAL_WITH_ACCUMULATOR, 2)
    |-> o_accum == ($past(o_accum, 2) & $past(i_literal, 2)) && o_zero == (o_accum == 8'h00)
    && o_carry == $past(o_carry, 2)) else $error("bad and literal");
  and_file_a: assert property (fin && $past(take && i_op == AND_FILE_WITH_ACCUMULATOR, 2)
    |-> o_zero == (o_result == 8'h00) && o_carry == $past(o_carry, 2)) else $error("bad and file");
  dest_select_a: assert property (fin && $past(take && i_op inside {AND_FILE_WITH_ACCUMULATOR,
    ADD_ACCUMULATOR_AND_FILE}, 2) |-> o_accum == ($past(i_dest, 2) ? $past(o_accum, 2) : o_result))
    else $error("bad destination");
  bit_flags_a: assert property (take && i_op inside {BIT_CLEAR_INSTR, BIT_SET_INSTR, TEST_SKIP_IF_ONE,
    TEST_SKIP_IF_ZERO} |=> ##1 {o_carry, o_nibble_overflow_bit, o_zero} == $past({o_carry,
    o_nibble_overflow_bit, o_zero}, 2)) else $error("flag moved");
  zero_file_a: assert property (fin && $past(take && i_op == ZERO_FILE_REGISTER, 2)
    |-> o_zero && o_result == 8'h00) else $error("bad clear");
  skip_if_one_a: assert property (fin && $past(take && i_op == TEST_SKIP_IF_ONE, 2)
    |-> o_skip == o_result[$past(i_bit_sel, 2)]) else $error("bad skip on one");
  skip_if_zero_a: assert property (fin && $past(take && i_op == TEST_SKIP_IF_ZERO, 2)
    |-> o_skip != o_result[$past(i_bit_sel, 2)]) else $error("bad skip on zero");
endmodule : alu_bit_exec_assertions
bind alu_bit_exec alu_bit_exec_assertions u_chk (.i_clk, .i_rst, .i_valid, .i_op, .i_dest, .i_bit_sel,
  .i_literal, .o_ready, .o_done, .o_skip, .o_discarded, .o_result, .o_accum, .o_carry,
  .o_nibble_overflow_bit, .o_zero);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb
  import alu_exec_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_valid = 1'b0;
  op_t i_op = NO_OPERATION;
  logic [6:0] i_file_addr = 7'h00;
  logic i_dest = 1'b0;
  logic [2:0] i_bit_sel = 3'h0;
  logic [7:0] i_literal = 8'h00;
  logic o_ready, o_done, o_skip, o_discarded, o_carry, o_nibble_overflow_bit, o_zero;
  logic [7:0] o_result, o_accum;
  logic [7:0] mem [128];
  logic [7:0] acc = 8'h00;
  logic [7:0] res = 8'h00;
  logic c = 1'b0, hc = 1'b0, z = 1'b0, skp = 1'b0;
  int err_count = 0;
  int n_tests = 0;
  alu_bit_exec DUT (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op), .i_file_addr(i_file_addr),
    .i_dest(i_dest), .i_bit_sel(i_bit_sel), .i_literal(i_literal), .o_ready(o_ready), .o_done(o_done),
    .o_skip(o_skip), .o_discarded(o_discarded), .o_result(o_result), .o_accum(o_accum), .o_carry(o_carry),
    .o_nibble_overflow_bit(o_nibble_overflow_bit), .o_zero(o_zero));
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // one instruction, issued at a falling edge; model predicts every output
  task automatic issue(input op_t op, input logic [6:0] a, input logic d, input logic [2:0] b, input logic [7:0] k);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] f;
    logic disc;
    logic ns;
    f = mem[a];
    disc = skp;
    ns = 1'b0;
    i_valid = 1'b1;
    i_op = op;
    {i_file_addr, i_dest, i_bit_sel, i_literal} = {a, d, b, k};
    chk("ready", o_ready, 1'b1);
    @(posedge i_clk);
    @(negedge i_clk);
    i_valid = 1'b0;
    chk("busy", o_ready, 1'b0);
    @(posedge i_clk);
    @(negedge i_clk);
    if (disc) skp = 1'b0;
    else begin
      case (op)
        ADD_LITERAL_TO_ACCUMULATOR, ADD_ACCUMULATOR_AND_FILE, AND_FILE_WITH_ACCUMULATOR,
        AND_LITERAL_WITH_ACCUMULATOR: begin
          if (op == ADD_LITERAL_TO_ACCUMULATOR || op == AND_LITERAL_WITH_ACCUMULATOR) f = k;
          s = {1'b0, acc} + {1'b0, f};
          n = acc[3:0] + f[3:0];
          if (op == ADD_LITERAL_TO_ACCUMULATOR || op == ADD_ACCUMULATOR_AND_FILE) begin
            {c, res} = s;
            hc = n[4];
          end else res = acc & f;
          z = res == 8'h00;
          if ((op == ADD_ACCUMULATOR_AND_FILE || op == AND_FILE_WITH_ACCUMULATOR) && d) mem[a] = res;
          else acc = res;
        end
        BIT_CLEAR_INSTR: res = f & ~(8'h01 << b);
        BIT_SET_INSTR: res = f | (8'h01 << b);
        TEST_SKIP_IF_ONE: {res, ns} = {f, f[b]};
        TEST_SKIP_IF_ZERO: {res, ns} = {f, ~f[b]};
        ZERO_FILE_REGISTER: {res, z} = {8'h00, 1'b1};
        default: res = f;
      endcase
      if (op inside {BIT_CLEAR_INSTR, BIT_SET_INSTR, ZERO_FILE_REGISTER}) mem[a] = res;
      skp = ns;
    end
    chk("done", o_done, 1'b1);
    chk("skip", o_skip, ns);
    chk("discarded", o_discarded, disc);
    chk("result", o_result, res);
    chk("accum", o_accum, acc);
    chk("flags", {o_carry, o_nibble_overflow_bit, o_zero}, {c, hc, z});
  endtask : issue
  task automatic t_arith();
    issue(ZERO_FILE_REGISTER, 7'h7F, 1'b0, 3'h0, 8'h00);
    issue(ADD_LITERAL_TO_ACCUMULATOR, 7'h00, 1'b0, 3'h0, 8'hFF);
    issue(ADD_LITERAL_TO_ACCUMULATOR, 7'h00, 1'b0, 3'h0, 8'h01);
    issue(ADD_LITERAL_TO_ACCUMULATOR, 7'h00, 1'b0, 3'h0, 8'h0F);
    issue(ADD_LITERAL_TO_ACCUMULATOR, 7'h00, 1'b0, 3'h0, 8'h01);
    issue(BIT_SET_INSTR, 7'h7F, 1'b0, 3'h7, 8'h00);
    issue(ADD_ACCUMULATOR_AND_FILE, 7'h7F, 1'b1, 3'h0, 8'h00);
    issue(ADD_ACCUMULATOR_AND_FILE, 7'h7F, 1'b0, 3'h0, 8'h00);
    issue(ADD_ACCUMULATOR_AND_FILE, 7'h7F, 1'b0, 3'h0, 8'h00);
  endtask : t_arith
  task automatic t_logic();
    issue(AND_LITERAL_WITH_ACCUMULATOR, 7'h00, 1'b0, 3'h0, 8'hF0);
    issue(AND_FILE_WITH_ACCUMULATOR, 7'h7F, 1'b1, 3'h0, 8'h00);
    issue(AND_FILE_WITH_ACCUMULATOR, 7'h7F, 1'b0, 3'h0, 8'h00);
    issue(AND_LITERAL_WITH_ACCUMULATOR, 7'h00, 1'b0, 3'h0, 8'h00);
    issue(NO_OPERATION, 7'h7F, 1'b0, 3'h0, 8'h00);
    issue(op_t'(4'hF), 7'h7F, 1'b0, 3'h0, 8'h00);
  endtask : t_logic
  // reset in mid-run clears state and a pending skip, file contents survive
  task automatic t_reset();
    issue(TEST_SKIP_IF_ONE, 7'h7F, 1'b0, 3'h4, 8'h00);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("rst ready", o_ready, 1'b1);
    chk("rst pulses", {o_done, o_skip, o_discarded}, 3'h0);
    chk("rst result", o_result, 8'h00);
    chk("rst accum", o_accum, 8'h00);
    chk("rst flags", {o_carry, o_nibble_overflow_bit, o_zero}, 3'h0);
    i_rst = 1'b0;
    {acc, res, c, hc, z, skp} = {8'h00, 8'h00, 4'h0};
    issue(ADD_LITERAL_TO_ACCUMULATOR, 7'h00, 1'b0, 3'h0, 8'h05);
    issue(AND_FILE_WITH_ACCUMULATOR, 7'h7F, 1'b0, 3'h0, 8'h00);
  endtask : t_reset
  task automatic t_bits();
    issue(ZERO_FILE_REGISTER, 7'h00, 1'b0, 3'h0, 8'h00);
    for (int b = 0; b < 8; b++) begin
      issue(BIT_SET_INSTR, 7'h00, 1'b0, 3'(b), 8'h00);
      issue(TEST_SKIP_IF_ONE, 7'h00, 1'b0, 3'(b), 8'h00);
      issue(ZERO_FILE_REGISTER, 7'h00, 1'b0, 3'h0, 8'h00);
      issue(TEST_SKIP_IF_ZERO, 7'h00, 1'b0, 3'(b), 8'h00);
      issue(BIT_CLEAR_INSTR, 7'h00, 1'b0, 3'(b), 8'h00);
      issue(TEST_SKIP_IF_ZERO, 7'h00, 1'b0, 3'(b), 8'h00);
      issue(TEST_SKIP_IF_ONE, 7'h00, 1'b0, 3'(b), 8'h00);
      issue(TEST_SKIP_IF_ONE, 7'h00, 1'b0, 3'(b), 8'h00);
    end
  endtask : t_bits
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    @(negedge i_clk);
    t_arith();
    t_logic();
    t_reset();
    t_bits();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
